// File: hw/fifo_rd_map.vh
`ifndef FIFO_RD_MAP_VH
`define FIFO_RD_MAP_VH
// almost-empty offset after reset
`define AE_OFFSET_RST     12'h07f
// control register bit positions used by the read side
`define CTRL_AE_SYNC_BIT  1
`define CTRL_OE_GATE_BIT  5
// expansion modes latched at reset (one-hot)
`define MODE_STANDALONE   4'h1
`define MODE_MASTER       4'h2
`define MODE_SLAVE        4'h4
`define MODE_PARALLEL     4'h8
// retransmit flag recovery, in read clock cycles
`define RT_ASYNC_CYC      3
`define RT_SYNC_CYC       4
// write-clock-synchronised flag recovery, in write clock edges
`define RT_WCLK_EDGES     2
`define RT_WCLK_EDGES_LATE 3
`endif

// File: hw/fifo_read_side_flags_token.v
`timescale 1ns/1ns
`include "fifo_rd_map.vh"
module fifo_read_side_flags_token #(
  parameter DEPTH = 4096,
  parameter AW    = 12
) (
  input  wire          ref_clk,
  input  wire          reset,
  input  wire          clk_en,
  input  wire          enhanced_select,
  input  wire          first_load_retransmit,
  input  wire          read_token_in_n,
  input  wire          write_token_in_n,
  input  wire          read_enable_n,
  input  wire          offset_load_n,
  input  wire          output_enable_n,
  input  wire [5:0]    ctrl_bits,
  input  wire          ae_offset_we,
  input  wire [AW:0]   ae_offset_wdata,
  input  wire [AW:0]   write_ptr,
  input  wire          write_commit,
  input  wire          write_skew_late,
  output reg           almost_empty_n,
  output reg           empty_n,
  output reg           read_token_out_n,
  output reg           read_strobe,
  output reg  [AW-1:0] read_addr,
  output reg           data_out_float,
  output reg           flags_settled,
  output reg           wflags_settled,
  output reg  [3:0]    mode
);

  // depth constant sized to meet pointer arithmetic
  localparam [AW:0] DEPTH_W = DEPTH[AW:0];
  localparam [AW-1:0] LAST_LOC = DEPTH_W[AW-1:0] - {{(AW-1){1'b0}}, 1'b1};

  reg [AW-1:0] rd_ptr_q;
  reg [AW:0]   ae_off_q;
  reg          written_q;
  reg          active_q;
  reg          token_pend_q;
  reg          empty_q;
  reg [2:0]    rt_cnt_q;
  reg [1:0]    wrt_cnt_q;
  reg          in_reset_q;

  // occupancy taken modulo depth; pointer width set by the parameter
  wire [AW:0] wr_ext  = write_ptr;
  wire [AW:0] rd_ext  = {1'b0, rd_ptr_q};
  wire [AW:0] diff_raw = wr_ext - rd_ext;
  wire [AW:0] fill    = (diff_raw >= DEPTH_W) ? diff_raw - DEPTH_W : diff_raw;

  wire enh       = mode[3] | (~enhanced_select);
  wire cascaded  = mode[1] | mode[2];
  wire is_empty  = (fill == {(AW+1){1'b0}}) | ~written_q;
  // read request from the pins, gated against empty below; load high and second enable in enhanced mode
  wire rd_req    = ~read_enable_n & offset_load_n &
                   (~enh | write_token_in_n) &
                   (~enh | ~ctrl_bits[`CTRL_OE_GATE_BIT] | ~output_enable_n);
  // reads use the registered empty flag, so a word written this cycle is seen next cycle;
  // the live compare also blocks the edge right after the last word, which would overread
  wire do_read   = rd_req & ~empty_q & ~is_empty & active_q;
  wire rt_req    = ~cascaded & first_load_retransmit & written_q & ~in_reset_q;
  wire ae_low    = fill < (ae_off_q + {{AW{1'b0}}, 1'b1});

  // slave role decided from the same inputs as the mode capture
  wire mode_slave_next = enhanced_select & read_token_in_n & write_token_in_n &
                         first_load_retransmit;

  // mode capture on the first enabled edge after reset; expansion inputs and first-load pick the cascade role
  always @(posedge ref_clk) begin
    if (reset) begin
      in_reset_q <= 1'b1;
      mode       <= `MODE_STANDALONE;
    end else if (clk_en) begin
      in_reset_q <= 1'b0;
      if (in_reset_q) begin
        if (~enhanced_select)
          mode <= `MODE_PARALLEL;
        else if (read_token_in_n & write_token_in_n)
          mode <= first_load_retransmit ? `MODE_SLAVE : `MODE_MASTER;
        else
          mode <= `MODE_STANDALONE;
      end
    end
  end

  // offset register; any value up to the depth is held, larger values clamp
  always @(posedge ref_clk) begin
    if (reset) begin
      ae_off_q <= `AE_OFFSET_RST;
    end else if (clk_en && ae_offset_we) begin
      ae_off_q <= (ae_offset_wdata > DEPTH_W) ? DEPTH_W : ae_offset_wdata;
    end
  end

  // read pointer, retransmit and token ring
  always @(posedge ref_clk) begin
    if (reset) begin
      rd_ptr_q     <= {AW{1'b0}};
      written_q    <= 1'b0;
      active_q     <= 1'b1;
      token_pend_q <= 1'b0;
      read_strobe  <= 1'b0;
      read_addr    <= {AW{1'b0}};
      data_out_float <= 1'b0;
      read_token_out_n <= 1'b1;
    end else if (clk_en) begin
      if (write_commit)
        written_q <= 1'b1;
      if (in_reset_q)
        active_q <= ~mode_slave_next;
      read_strobe <= do_read;
      read_addr   <= rd_ptr_q;
      if (rt_req) begin
        rd_ptr_q <= {AW{1'b0}};
      end else if (do_read) begin
        rd_ptr_q <= (rd_ptr_q == LAST_LOC) ? {AW{1'b0}} : rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      token_pend_q <= do_read & cascaded & (rd_ptr_q == LAST_LOC);
      // token pulse one cycle wide; reading then stops and outputs float
      if (cascaded && token_pend_q) begin
        read_token_out_n <= 1'b0;
        active_q         <= 1'b0;
        data_out_float   <= 1'b1;
      end else if (cascaded && !read_token_in_n && !active_q) begin
        read_token_out_n <= 1'b1;
        active_q         <= 1'b1;
        data_out_float   <= 1'b0;
      end else if (cascaded) begin
        read_token_out_n <= 1'b1;
      end else if (enh) begin
        read_token_out_n <= empty_n;
      end else begin
        read_token_out_n <= 1'b1;
      end
    end
  end

  // flags: empty always read-clocked; almost-empty follows the offset compare one cycle later in every mode
  always @(posedge ref_clk) begin
    if (reset) begin
      empty_q        <= 1'b1;
      empty_n        <= 1'b0;
      almost_empty_n <= 1'b0;
    end else if (clk_en) begin
      empty_q <= is_empty;
      empty_n <= ~is_empty;
      if (enh && ctrl_bits[`CTRL_AE_SYNC_BIT])
        almost_empty_n <= ~ae_low;
      else if (ae_low)
        almost_empty_n <= 1'b0;
      else if (write_commit | ~almost_empty_n)
        almost_empty_n <= 1'b1;
    end
  end

  // retransmit recovery: settled strobes after 3 or 4 read cycles, 2 or 3 write edges
  always @(posedge ref_clk) begin
    if (reset) begin
      rt_cnt_q       <= 3'h0;
      wrt_cnt_q      <= 2'h0;
      flags_settled  <= 1'b1;
      wflags_settled <= 1'b1;
    end else if (clk_en) begin
      if (rt_req) begin
        rt_cnt_q       <= (ctrl_bits[`CTRL_AE_SYNC_BIT] & enh) ? 3'h4 : 3'h3;
        wrt_cnt_q      <= write_skew_late ? 2'h3 : 2'h2;
        flags_settled  <= 1'b0;
        wflags_settled <= 1'b0;
      end else begin
        if (rt_cnt_q != 3'h0)
          rt_cnt_q <= rt_cnt_q - 3'h1;
        flags_settled <= (rt_cnt_q <= 3'h1);
        if (write_commit && wrt_cnt_q != 2'h0)
          wrt_cnt_q <= wrt_cnt_q - 2'h1;
        wflags_settled <= (wrt_cnt_q == 2'h0) |
                          (write_commit & (wrt_cnt_q == 2'h1));
      end
    end
  end

endmodule

// File: bench/fifo_rd_properties.sv
`timescale 1ns/1ns
`include "fifo_rd_map.vh"
// port timing checks of the read-side flag and token block
module fifo_rd_properties #(
  parameter DEPTH = 4096,
  parameter AW    = 12
) (
  input wire logic       ref_clk, reset, read_enable_n, offset_load_n,
  input wire logic       empty_n, almost_empty_n, read_token_out_n,
  input wire logic       read_strobe, data_out_float, flags_settled,
  input wire logic [5:0] ctrl_bits,
  input wire logic [3:0] mode
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // async recovery is three low cycles, then settled again
  sequence s_settle3;
    !flags_settled[*3] ##1 flags_settled;
  endsequence
  a_reset_flags_low: assert property ($fell(reset) |-> !empty_n && !almost_empty_n)
    else $error("flags not low after reset");
  a_read_blocked_empty: assert property (!empty_n |=> !read_strobe)
    else $error("read while empty");
  a_standalone_token_high: assert property (mode == `MODE_STANDALONE |-> read_token_out_n)
    else $error("token output low in standalone");
  a_delayed_empty_copy: assert property (mode == `MODE_PARALLEL |=>
    read_token_out_n == $past(empty_n)) else $error("delayed empty mismatch");
  a_first_word_read: assert property ($rose(empty_n) && !read_enable_n && offset_load_n
    && mode == `MODE_STANDALONE |=> read_strobe) else $error("first word not read");
  a_retx_async_settle: assert property ($fell(flags_settled) && !ctrl_bits[1] |-> s_settle3)
    else $error("retransmit recovery length wrong");
  a_token_single_pulse: assert property ($fell(read_token_out_n) && mode == `MODE_MASTER
    |=> read_token_out_n) else $error("token pulse too long");
  a_float_after_token: assert property (mode == `MODE_MASTER && !read_token_out_n
    |-> ##[1:2] data_out_float) else $error("outputs not floated");
endmodule
bind fifo_read_side_flags_token fifo_rd_properties #(.DEPTH(DEPTH), .AW(AW)) u_props (
  .ref_clk, .reset, .read_enable_n, .offset_load_n, .empty_n, .almost_empty_n,
  .read_token_out_n, .read_strobe, .data_out_float, .flags_settled, .ctrl_bits, .mode);

// File: bench/read_consumer.sv
`timescale 1ns/1ns
// reader on the far side: requests reads while told to, even when empty
module read_consumer (
  input  wire logic go,
  output wire logic read_enable_n
);
  assign read_enable_n = !go;
endmodule

// File: bench/tb_fifo_read_side_flags_token.sv
`timescale 1ns/1ns
module tb_fifo_read_side_flags_token;
  logic ref_clk = 0, reset = 1, es = 1, fl = 0, rti = 0, wti = 0, go = 0, we = 0, wc = 0, e;
  logic [11:0] off = 12'h07f, wp = 12'h000;
  logic        ce = 1;
  logic [5:0]  cb = 6'h00;
  logic [10:0] ra, last;
  logic [3:0] mode;
  logic       ren_n, aen, en, tok, rs, flt, fs;
  integer     nrd = 0, base, i, miscompares = 0, checked = 0;
  // offset, write count, expected almost-empty
  logic [24:0] rows [5] = '{{12'h07f, 12'h001, 1'b0}, {12'h004, 12'h004, 1'b0},
    {12'h004, 12'h005, 1'b1}, {12'h07f, 12'h07f, 1'b0}, {12'h07f, 12'h080, 1'b1}};
  initial forever #20 ref_clk = ~ref_clk;
  // smaller depth keeps the token walk short
  fifo_read_side_flags_token #(.DEPTH(2048), .AW(11)) i_fifo_read_side_flags_token (
    .ref_clk(ref_clk), .reset(reset), .clk_en(ce), .enhanced_select(es),
    .first_load_retransmit(fl), .read_token_in_n(rti), .write_token_in_n(wti),
    .read_enable_n(ren_n), .offset_load_n(1'b1), .output_enable_n(1'b0),
    .ctrl_bits(cb), .ae_offset_we(we), .ae_offset_wdata(off), .write_ptr(wp),
    .write_commit(wc), .write_skew_late(1'b0), .almost_empty_n(aen), .empty_n(en),
    .read_token_out_n(tok), .read_strobe(rs), .read_addr(ra), .data_out_float(flt),
    .flags_settled(fs), .wflags_settled(), .mode(mode));
  read_consumer i_read_consumer (.go(go), .read_enable_n(ren_n));
  // count reads and keep the last address
  always @(posedge ref_clk) if (rs === 1'b1) begin
    nrd <= nrd + 1;
    last <= ra;
  end
  task chk(input [15:0] got, input [15:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(negedge ref_clk);
  endtask
  task rst(input s, input t, input f);
    {es, wti, rti, fl, wp} = {s, t, t, f, 12'h000};
    reset = 1;
    cyc(16);
    reset = 0;
    cyc(2);
  endtask
  task commit;
    wc = 1;
    cyc(1);
    wc = 0;
    cyc(2);
  endtask
  task final_report;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    @(negedge ref_clk);
    rst(1, 0, 0);
    chk(mode, 4'h1);
    fl = 1;
    cyc(1);
    fl = 0;
    cyc(5);
    chk({en, aen, fs}, 3'h1);
    for (i = 0; i < 5; i++) begin
      {off, wp, e} = rows[i];
      we = 1;
      cyc(1);
      we = 0;
      commit();
      chk({en, aen}, {1'b1, e});
    end
    base = nrd;
    go = 1;
    for (i = 0; i < 300 && en; i++) cyc(1);
    chk(i < 300, 1);
    cyc(3);
    go = 0;
    cyc(2);
    chk(nrd - base, 128);
    chk({en, last}, 12'h07f);
    fl = 1;
    cyc(1);
    fl = 0;
    cyc(6);
    go = 1;
    cyc(1);
    go = 0;
    cyc(2);
    chk(last, 0);
    rst(0, 1, 1);
    chk(mode, 4'h8);
    fl = 0;
    wp = 12'h003;
    commit();
    base = nrd;
    go = 1;
    cyc(8);
    go = 0;
    chk(nrd - base, 3);
    rst(1, 1, 0);
    chk(mode, 4'h2);
    wp = 12'h400;
    commit();
    base = nrd;
    go = 1;
    for (i = 0; i < 1100 && en; i++) cyc(1);
    chk(i < 1100, 1);
    wp = 12'h800;
    commit();
    for (i = 0; i < 1100 && tok; i++) cyc(1);
    chk(i < 1100, 1);
    go = 0;
    cyc(2);
    chk(nrd - base, 2048);
    chk(flt, 1);
    rti = 0;
    cyc(1);
    rti = 1;
    cyc(2);
    chk(flt, 0);
    final_report();
  end
endmodule
